// ---- tb/pcisr_cfg_master.sv ----
`timescale 1ns/10ps
`default_nettype none

// Upstream port model that issues configuration reads and writes.
module pcisr_cfg_master (
  input  wire logic        clk,
  input  wire logic [15:0] cfg_rdata,
  input  wire logic        cfg_rd_valid,
  output var  logic        cfg_rd,
  output var  logic        cfg_wr,
  output var  logic [7:0]  cfg_addr,
  output var  logic [1:0]  cfg_be,
  output var  logic [15:0] cfg_wdata
);
  // The bus starts idle with no request pending.
  initial begin
    cfg_rd    = 1'b0;
    cfg_wr    = 1'b0;
    cfg_addr  = 8'h00;
    cfg_be    = 2'b00;
    cfg_wdata = 16'h0000;
  end

  // Idle fields show the inverse of the last value, so a stale bus never looks valid.
  task automatic release_bus();
    cfg_rd    = 1'b0;
    cfg_wr    = 1'b0;
    cfg_addr  = ~cfg_addr;
    cfg_be    = ~cfg_be;
    cfg_wdata = ~cfg_wdata;
  endtask : release_bus

  // Called just after a falling edge; the answer comes one cycle after the request.
  // An idle cycle follows every transfer so that no field is driven twice in one step.
  task automatic cfg_read(input logic [7:0] addr, output logic [15:0] data);
    cfg_rd   = 1'b1;
    cfg_addr = addr;
    @(negedge clk);
    data = (cfg_rd_valid === 1'b1) ? cfg_rdata : 16'hxxxx;
    release_bus();
    @(negedge clk);
  endtask : cfg_read

  // A one in the data clears the matching flag when the upper byte is enabled.
  task automatic cfg_write(input logic [7:0] addr, input logic [1:0] be, input logic [15:0] d);
    cfg_wr    = 1'b1;
    cfg_addr  = addr;
    cfg_be    = be;
    cfg_wdata = d;
    @(negedge clk);
    release_bus();
    @(negedge clk);
  endtask : cfg_write
endmodule : pcisr_cfg_master

`default_nettype wire

// ---- tb/pcisr_status_reg_test.sv ----
`timescale 1ns/10ps
`default_nettype none

module pcisr_status_reg_test;
  logic        clk;
  logic        rst_n;
  logic        sys_en;
  logic        par_en;
  logic [6:0]  ev;
  logic        rd, wr, rd_valid;
  logic [7:0]  addr;
  logic [1:0]  be;
  logic [15:0] wdata, rdata;
  int          failures;
  int          check_count;
  int          i;
  // Flag each event source should raise, in the order of the event vector.
  localparam logic [15:0] FLAG_OF [7] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000,
                                          16'h0800, 16'h0100, 16'h0100};

  pcisr_status_reg pcisr_status_reg_i (.clk(clk), .rst_n(rst_n), .cfg_rd(rd), .cfg_wr(wr),
    .cfg_addr(addr), .cfg_be(be), .cfg_wdata(wdata), .cfg_rdata(rdata),
    .cfg_rd_valid(rd_valid), .system_error_enable(sys_en), .parity_response_enable(par_en),
    .poisoned_tlp_rx(ev[0]), .err_msg_tx(ev[1]), .ur_cpl_rx(ev[2]), .ca_cpl_rx(ev[3]),
    .ca_cpl_tx(ev[4]), .poisoned_cpl_data_rx(ev[5]), .poisoned_wr_req(ev[6]));

  pcisr_cfg_master pcisr_cfg_master_i (.clk(clk), .cfg_rdata(rdata), .cfg_rd_valid(rd_valid),
    .cfg_rd(rd), .cfg_wr(wr), .cfg_addr(addr), .cfg_be(be), .cfg_wdata(wdata));

  // A 4 ns period gives the 250 MHz core clock.
  always #2 clk = ~clk;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    pcisr_cfg_master_i.cfg_read(a, d);
    chk(d, exp);
  endtask : rdc

  task automatic conclude();
    $display("failures=%0d check_count=%0d", failures, check_count);
    if (failures == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  // The whole sequence needs well under a thousand cycles.
  initial begin
    #20000;
    failures++;
    conclude();
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    sys_en = 1'b1;
    par_en = 1'b1;
    ev = 7'h00;
    failures = 0;
    check_count = 0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    rdc(8'h06, 16'h0010);
    rdc(8'h07, 16'h0010);
    // Each source raises its flag by the next cycle; a write of ones clears it.
    for (i = 0; i < 7; i++) begin
      ev[i] = 1'b1;
      @(negedge clk);
      ev[i] = 1'b0;
      rdc(8'h06, 16'h0010 | FLAG_OF[i]);
      pcisr_cfg_master_i.cfg_write(8'h06, 2'b10, 16'hFFFF);
      rdc(8'h06, 16'h0010);
    end
    // With both enables low only the ungated poisoned packet sticks.
    sys_en = 1'b0;
    par_en = 1'b0;
    ev = 7'b110_0011;
    @(negedge clk);
    ev = 7'h00;
    rdc(8'h06, 16'h8010);
    // Lower byte only, zero data and an unmapped address all leave the flag.
    pcisr_cfg_master_i.cfg_write(8'h06, 2'b01, 16'hFFFF);
    pcisr_cfg_master_i.cfg_write(8'h06, 2'b10, 16'h0000);
    pcisr_cfg_master_i.cfg_write(8'h08, 2'b11, 16'hFFFF);
    rdc(8'h06, 16'h8010);
    rdc(8'h08, 16'h0000);
    // Events in the clearing cycle win over the clear, for a set and a clear flag alike.
    fork
      pcisr_cfg_master_i.cfg_write(8'h06, 2'b10, 16'hA000);
      begin
        ev = 7'h05;
        @(negedge clk);
        ev = 7'h00;
      end
    join
    rdc(8'h06, 16'hA010);
    pcisr_cfg_master_i.cfg_write(8'h06, 2'b11, 16'hA6EF);
    rdc(8'h06, 16'h0010);
    // A reset in mid-run drops a pending flag.
    ev[2] = 1'b1;
    @(negedge clk);
    ev[2] = 1'b0;
    rdc(8'h06, 16'h2010);
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    rdc(8'h06, 16'h0010);
    conclude();
  end
endmodule : pcisr_status_reg_test

`default_nettype wire

// ---- verilog/pcisr_flag_bank.sv ----
`timescale 1ns/10ps
`default_nettype none

module pcisr_flag_bank (
  input  wire logic clk,
  input  wire logic rst_n,
  pcisr_flag_if.bank fl
);

  logic [15:0] flags_q;
  logic [15:0] flags_d;

  // A set in the same cycle as a clear wins, so no event is lost to a clear.
  always_comb begin
    flags_d = ((flags_q & ~fl.clr) | fl.set) & pcisr_pkg::FLAG_MASK;
  end

  // Only the flag positions are stored; every other bit is fixed in the read image.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= pcisr_pkg::FLAG_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign fl.flags = flags_q;

  // No bit outside the flag positions can ever become set.
  stray_bits_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    (flags_q & ~pcisr_pkg::FLAG_MASK) == pcisr_pkg::ALL_ZERO)
    else $error("flag store holds a bit outside the flag positions");

  // A flag with no set and no clear keeps its value.
  hold_flags_a: assert property (@(posedge clk) disable iff (!rst_n)
    (fl.set == pcisr_pkg::ALL_ZERO && fl.clr == pcisr_pkg::ALL_ZERO) |=> $stable(flags_q))
    else $error("flag changed without a set or clear");

endmodule : pcisr_flag_bank

`default_nettype wire

// ---- verilog/pcisr_flag_if.sv ----
`timescale 1ns/10ps
`default_nettype none

// Carries set and clear requests to the flag store and the stored flags back.
interface pcisr_flag_if;
  logic [15:0] set;
  logic [15:0] clr;
  logic [15:0] flags;

  modport bank (input set, input clr, output flags);
  modport ctrl (output set, output clr, input flags);
endinterface : pcisr_flag_if

`default_nettype wire

// ---- verilog/pcisr_pkg.sv ----
`default_nettype none

package pcisr_pkg;

  // Byte offset of the status word in configuration space.
  localparam logic [7:0]  STATUS_OFFSET     = 8'h06;
  // Value of the whole word after reset: only the capability chain bit is one.
  localparam logic [15:0] STATUS_RESET      = 16'h0010;

  // Bit positions of the software-clearable error flags.
  localparam int          POISONED_RX_BIT   = 15;
  localparam int          FATAL_MSG_BIT     = 14;
  localparam int          UNSUP_CPL_RX_BIT  = 13;
  localparam int          CA_RX_BIT         = 12;
  localparam int          CA_TX_BIT         = 11;
  localparam int          MASTER_POISON_BIT = 8;

  // Bit positions of the fixed fields.
  localparam int          DEVSEL_LSB        = 9;
  localparam int          DEVSEL_MSB        = 10;
  localparam int          BACK_TO_BACK_BIT  = 7;
  localparam int          HIGH_SPEED_BIT    = 5;
  localparam int          CAP_CHAIN_BIT     = 4;
  localparam int          INT_PENDING_BIT   = 3;

  // Which bits hold flags, which read as constant one, which read as zero.
  localparam logic [15:0] FLAG_MASK         = 16'hF900;
  localparam logic [15:0] CONST_ONE_MASK    = 16'h0010;
  localparam logic [15:0] CONST_ZERO_MASK   = 16'h06EF;
  // Reserved positions only: bit 6 and bits 2 to 0.
  localparam logic [15:0] RESERVED_MASK     = 16'h0047;
  localparam logic [15:0] FLAG_RESET        = 16'h0000;
  localparam logic [15:0] ALL_ZERO          = 16'h0000;

endpackage : pcisr_pkg

`default_nettype wire

// ---- verilog/pcisr_status_reg.sv ----
// How it works
// - A poisoned packet received on the link sets flag bit 15 whatever the parity enable says.
// - Sending a fatal or nonfatal error message sets flag bit 14 only while the system-error enable is high.
// - Receiving a completion with unsupported-request status sets flag bit 13.
// - Receiving a completion with completer-abort status sets flag bit 12.
// - Answering a request with a completer-abort completion sets flag bit 11.
// - The select-timing field in bits 10 to 9 always reads as zero.
// - With the parity enable high, a poisoned data completion or a poisoned write sets flag bit 8.
// - Bit 7, the back-to-back capability, always reads as zero.
// - Bit 5, the high-speed capability, always reads as zero.
// - Bit 4 always reads as one to show that a capability chain is present.
// - Bit 3, the interrupt-pending indication, always reads as zero.
// - Reserved bit 6 and reserved bits 2 to 0 always read as zero.
// - The word sits at offset 06h, resets to 0010h, and only its flag bits can change.
`timescale 1ns/10ps
`default_nettype none

module pcisr_status_reg (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        cfg_rd,
  input  wire logic        cfg_wr,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [1:0]  cfg_be,
  input  wire logic [15:0] cfg_wdata,
  output var  logic [15:0] cfg_rdata,
  output var  logic        cfg_rd_valid,
  input  wire logic        system_error_enable,
  input  wire logic        parity_response_enable,
  input  wire logic        poisoned_tlp_rx,
  input  wire logic        err_msg_tx,
  input  wire logic        ur_cpl_rx,
  input  wire logic        ca_cpl_rx,
  input  wire logic        ca_cpl_tx,
  input  wire logic        poisoned_cpl_data_rx,
  input  wire logic        poisoned_wr_req
);

  // The word decodes on its 16-bit pair of bytes, so 06h and 07h both reach it.
  function automatic logic addr_hit(input logic [7:0] addr);
    addr_hit = (addr[7:1] == pcisr_pkg::STATUS_OFFSET[7:1]);
  endfunction : addr_hit

  // Builds the value software sees from the stored flags and the fixed fields.
  function automatic logic [15:0] read_image(input logic [15:0] flags);
    // Masking to the flag positions forces every fixed-zero field low.
    read_image = (flags & pcisr_pkg::FLAG_MASK) | pcisr_pkg::CONST_ONE_MASK;
  endfunction : read_image

  pcisr_flag_if fl ();

  logic        rd_hit;
  logic        wr_hit;
  logic        fatal_evt;
  logic        master_poison_evt;
  logic [15:0] cfg_rdata_q;
  logic [15:0] cfg_rdata_d;
  logic        cfg_rd_valid_q;

  // Access decode shared by the read and the write path.
  assign rd_hit = cfg_rd && addr_hit(cfg_addr);
  assign wr_hit = cfg_wr && addr_hit(cfg_addr);

  // The two enable-gated events; the other four flags take their event as is.
  assign fatal_evt         = err_msg_tx && system_error_enable;
  assign master_poison_evt = parity_response_enable &&
                             (poisoned_cpl_data_rx || poisoned_wr_req);

  // Hardware events mapped onto their flag positions.
  always_comb begin
    fl.set                               = pcisr_pkg::ALL_ZERO;
    fl.set[pcisr_pkg::POISONED_RX_BIT]   = poisoned_tlp_rx;
    fl.set[pcisr_pkg::FATAL_MSG_BIT]     = fatal_evt;
    fl.set[pcisr_pkg::UNSUP_CPL_RX_BIT]  = ur_cpl_rx;
    fl.set[pcisr_pkg::CA_RX_BIT]         = ca_cpl_rx;
    fl.set[pcisr_pkg::CA_TX_BIT]         = ca_cpl_tx;
    fl.set[pcisr_pkg::MASTER_POISON_BIT] = master_poison_evt;
  end

  // Every flag sits in the upper byte, so only that lane can clear anything.
  // Ones written to read-only positions are masked off and have no effect.
  always_comb begin
    fl.clr = pcisr_pkg::ALL_ZERO;
    if (wr_hit && cfg_be[1]) begin
      fl.clr = cfg_wdata & pcisr_pkg::FLAG_MASK;
    end
  end

  pcisr_flag_bank u_flag_bank (
    .clk   (clk),
    .rst_n (rst_n),
    .fl    (fl)
  );

  // A read returns the word as it stood before any clear in the same cycle.
  // Unmapped reads answer zero so a stray access never looks like an error.
  always_comb begin
    cfg_rdata_d = pcisr_pkg::ALL_ZERO;
    if (rd_hit) begin
      cfg_rdata_d = read_image(fl.flags);
    end
  end

  // Read data register; it stores the whole read image, fixed fields included, on each read of the word, and zero on other reads.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata_q <= pcisr_pkg::ALL_ZERO;
    end else if (cfg_rd) begin
      cfg_rdata_q <= cfg_rdata_d;
    end
  end

  // Read answer strobe, one cycle after each read request.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rd_valid_q <= 1'b0;
    end else begin
      cfg_rd_valid_q <= cfg_rd;
    end
  end

  assign cfg_rdata    = cfg_rdata_q;
  assign cfg_rd_valid = cfg_rd_valid_q;

  // Checks below share one clock and the block reset.
  default clocking chk_cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // A read of the word, in the cycle of the request only; the answer is not part of it.
  sequence rd_req_s;
    rd_hit;
  endsequence

  // A write that asks to clear the poisoned-packet flag with no new event.
  sequence clr_poison_s;
    wr_hit && cfg_be[1] && cfg_wdata[pcisr_pkg::POISONED_RX_BIT] && !poisoned_tlp_rx;
  endsequence

  // A clear of bit 13 that collides with a fresh unsupported completion.
  sequence clr_unsup_collide_s;
    wr_hit && cfg_be[1] && cfg_wdata[pcisr_pkg::UNSUP_CPL_RX_BIT] && ur_cpl_rx;
  endsequence

  // Two cycles with no new poisoned packet, the second one a read of the word.
  sequence quiet_read_s;
    !poisoned_tlp_rx ##1 (rd_hit && !poisoned_tlp_rx);
  endsequence

  // A clear of bit 12 with no fresh completer abort in the same cycle.
  sequence clr_abort_s;
    wr_hit && cfg_be[1] && cfg_wdata[pcisr_pkg::CA_RX_BIT] && !ca_cpl_rx;
  endsequence

  // A write of the word that enables the lower byte lane only.
  sequence low_lane_only_s;
    wr_hit && cfg_be == 2'h1;
  endsequence

  poison_rx_sets_a: assert property (
    poisoned_tlp_rx |=> fl.flags[pcisr_pkg::POISONED_RX_BIT])
    else $error("poisoned packet did not set bit 15");

  fatal_msg_sets_a: assert property (
    fatal_evt |=> fl.flags[pcisr_pkg::FATAL_MSG_BIT])
    else $error("error message with enable did not set bit 14");

  fatal_msg_gated_a: assert property (
    $rose(fl.flags[pcisr_pkg::FATAL_MSG_BIT]) |-> $past(fatal_evt))
    else $error("bit 14 rose without an enabled error message");

  unsup_cpl_sets_a: assert property (
    ur_cpl_rx |=> fl.flags[pcisr_pkg::UNSUP_CPL_RX_BIT])
    else $error("unsupported completion did not set bit 13");

  abort_rx_sets_a: assert property (
    ca_cpl_rx |=> fl.flags[pcisr_pkg::CA_RX_BIT])
    else $error("received completer abort did not set bit 12");

  abort_tx_sets_a: assert property (
    ca_cpl_tx |=> fl.flags[pcisr_pkg::CA_TX_BIT])
    else $error("signalled completer abort did not set bit 11");

  master_poison_gated_a: assert property (
    $rose(fl.flags[pcisr_pkg::MASTER_POISON_BIT]) |-> $past(master_poison_evt))
    else $error("bit 8 rose without enabled poisoned data");

  master_poison_sets_a: assert property (
    master_poison_evt |=> fl.flags[pcisr_pkg::MASTER_POISON_BIT])
    else $error("enabled poisoned data did not set bit 8");

  fixed_zero_bits_a: assert property (
    rd_req_s |=> cfg_rd_valid && (cfg_rdata & pcisr_pkg::CONST_ZERO_MASK) == pcisr_pkg::ALL_ZERO)
    else $error("a fixed-zero bit read back as one");

  cap_chain_one_a: assert property (
    rd_req_s |=> cfg_rd_valid && cfg_rdata[pcisr_pkg::CAP_CHAIN_BIT])
    else $error("capability chain bit read back as zero");

  read_matches_a: assert property (
    rd_req_s |=> cfg_rdata == (($past(fl.flags) & pcisr_pkg::FLAG_MASK) | pcisr_pkg::CONST_ONE_MASK))
    else $error("read data does not match the stored flags");

  unmapped_read_zero_a: assert property (
    cfg_rd && !addr_hit(cfg_addr) |=> cfg_rd_valid && cfg_rdata == pcisr_pkg::ALL_ZERO)
    else $error("unmapped read did not return zero");

  clear_then_read_a: assert property (
    clr_poison_s ##1 quiet_read_s |=> !cfg_rdata[pcisr_pkg::POISONED_RX_BIT])
    else $error("cleared flag read back as set");

  set_beats_clear_a: assert property (
    clr_unsup_collide_s |=> fl.flags[pcisr_pkg::UNSUP_CPL_RX_BIT])
    else $error("clear in the cycle of an event lost the event");

  zero_write_keeps_a: assert property (
    wr_hit && fl.flags[pcisr_pkg::CA_RX_BIT] && !cfg_wdata[pcisr_pkg::CA_RX_BIT]
      |=> fl.flags[pcisr_pkg::CA_RX_BIT])
    else $error("writing zero cleared a flag");

  low_lane_no_clear_a: assert property (
    wr_hit && !cfg_be[1] && fl.flags[pcisr_pkg::CA_TX_BIT] |=> fl.flags[pcisr_pkg::CA_TX_BIT])
    else $error("write without the upper lane cleared a flag");

  poison_beats_clear_a: assert property (
    wr_hit && cfg_be[1] && cfg_wdata[pcisr_pkg::POISONED_RX_BIT] && poisoned_tlp_rx
      |=> fl.flags[pcisr_pkg::POISONED_RX_BIT])
    else $error("clear in the cycle of a poisoned packet lost the event");

  // Each fixed field is checked on its own so that a failure names the field.
  select_timing_zero_a: assert property (
    rd_req_s |=> cfg_rdata[pcisr_pkg::DEVSEL_MSB:pcisr_pkg::DEVSEL_LSB] == 2'h0)
    else $error("select-timing field read back as nonzero");

  fast_cap_zero_a: assert property (
    rd_req_s |=> !cfg_rdata[pcisr_pkg::BACK_TO_BACK_BIT])
    else $error("back-to-back capability bit read back as one");

  speed_cap_zero_a: assert property (
    rd_req_s |=> !cfg_rdata[pcisr_pkg::HIGH_SPEED_BIT])
    else $error("high-speed capability bit read back as one");

  int_pending_zero_a: assert property (
    rd_req_s |=> !cfg_rdata[pcisr_pkg::INT_PENDING_BIT])
    else $error("interrupt-pending bit read back as one");

  reserved_zero_a: assert property (
    rd_req_s |=> (cfg_rdata & pcisr_pkg::RESERVED_MASK) == pcisr_pkg::ALL_ZERO)
    else $error("a reserved bit read back as one");

  // A flag may only rise in the cycle after its own event.
  poison_rx_cause_a: assert property (
    $rose(fl.flags[pcisr_pkg::POISONED_RX_BIT]) |-> $past(poisoned_tlp_rx))
    else $error("bit 15 rose without a poisoned packet");

  unsup_cpl_cause_a: assert property (
    $rose(fl.flags[pcisr_pkg::UNSUP_CPL_RX_BIT]) |-> $past(ur_cpl_rx))
    else $error("bit 13 rose without an unsupported completion");

  abort_rx_cause_a: assert property (
    $rose(fl.flags[pcisr_pkg::CA_RX_BIT]) |-> $past(ca_cpl_rx))
    else $error("bit 12 rose without a received completer abort");

  abort_tx_cause_a: assert property (
    $rose(fl.flags[pcisr_pkg::CA_TX_BIT]) |-> $past(ca_cpl_tx))
    else $error("bit 11 rose without a signalled completer abort");

  // With its enable low an event leaves a clear gated flag clear.
  fatal_msg_blocked_a: assert property (
    err_msg_tx && !system_error_enable && !fl.flags[pcisr_pkg::FATAL_MSG_BIT]
      |=> !fl.flags[pcisr_pkg::FATAL_MSG_BIT])
    else $error("error message without enable set bit 14");

  master_poison_blocked_a: assert property (
    (poisoned_cpl_data_rx || poisoned_wr_req) && !parity_response_enable
      && !fl.flags[pcisr_pkg::MASTER_POISON_BIT]
      |=> !fl.flags[pcisr_pkg::MASTER_POISON_BIT])
    else $error("poisoned data without enable set bit 8");

  // A one in a flag position clears it when the upper lane is enabled; other writes never lose a flag.
  clear_takes_a: assert property (
    clr_abort_s |=> !fl.flags[pcisr_pkg::CA_RX_BIT])
    else $error("writing one did not clear bit 12");

  low_lane_keeps_a: assert property (
    low_lane_only_s |=> (fl.flags & $past(fl.flags)) == $past(fl.flags))
    else $error("lower-lane write cleared a flag");

  unmapped_write_keeps_a: assert property (
    cfg_wr && !addr_hit(cfg_addr) |=> (fl.flags & $past(fl.flags)) == $past(fl.flags))
    else $error("write to another offset cleared a flag");

  // Every read is answered exactly one cycle later, and the data then holds.
  rd_answer_a: assert property (
    cfg_rd |=> cfg_rd_valid)
    else $error("read was not answered in the next cycle");

  rd_valid_pulse_a: assert property (
    !cfg_rd |=> !cfg_rd_valid)
    else $error("read answer strobe without a read");

  rdata_holds_a: assert property (
    !cfg_rd |=> $stable(cfg_rdata))
    else $error("read data changed without a read");

  // An event during reset is lost by design, so the word leaves reset clean.
  reset_value_a: assert property (
    $rose(rst_n) |-> fl.flags == pcisr_pkg::FLAG_RESET && cfg_rdata == pcisr_pkg::ALL_ZERO
      && !cfg_rd_valid)
    else $error("word left reset with a flag or answer pending");

endmodule : pcisr_status_reg

`default_nettype wire
